// file: fprot_core.sv
// Functional notes
// (RULE1) Security write sets lockdown, freezing OTP
// (RULE2) Chip select must rise on byte boundary
// (RULE3) Mode bit picks range or per-block protection
// (RULE4) Mode bit once set never clears
// (RULE5) Per-block mode powers up fully locked
// (RULE6) Locked regions refuse program/erase until unlocked
// (RULE7) Range bits frozen by disable bit, wp low
// (RULE8) Wp low protects all in per-block mode
// (RULE9) Mode-select command sets mode bit
// (RULE10) Lock commands need per-block mode
// (RULE11) Single lock sets, unlock clears one bit
// (RULE12) Single lock/unlock: opcode plus four address bytes
// (RULE13) Address picks 64K block or 4K sector
// (RULE14) Lock commands need prior write enable
// (RULE15) Lock status read returns status byte
// (RULE16) Status one means protected, zero writable
// (RULE17) Global lock/unlock affects every block
// (RULE18) Flag-clear resets program and erase fail
// (RULE19) Host clears flags before next block
// (RULE20) Ready-output enable drives ready on SO
// (RULE21) Ready-output disable stops driving SO
// (RULE22) Table read: opcode, three address, one dummy
// (RULE23) Chip select rise ends table read cleanly
// (RULE24) Flag-clear opcode is 30h
// (RULE25) Failed or blocked program sets fail flag
// (RULE26) Rejected commands change no protection state
// (RULE27) Rising-edge MSB-first sampling, restart per frame
`timescale 1ns/1ps
`default_nettype none
`include "fprot_defs.svh"

module fprot_core import fprot_pkg::*; #(
    parameter int NUM_BLOCKS = 512,
    parameter logic [7:0] OP_SEC_WR = 8'h2F,
    parameter logic [7:0] OP_MODESEL = 8'h68,
    parameter logic [7:0] OP_WR_EN = 8'h06,
    parameter logic [7:0] OP_WRDI = 8'h04,
    parameter logic [7:0] OP_RDY_ON = 8'h70,
    parameter logic [7:0] OP_RDY_OFF = 8'h80
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    // Ready/busy on SO between frames
    output logic rdy_so_out,
    output logic rdy_so_oe,
    // Pins and status from the rest of the device
    input wire logic wp_n,
    input wire logic status_write_disable_bit,
    input wire logic continuous_program_mode,
    input wire logic ready_busy_n,
    input wire logic factory_lock,
    // Non-volatile images loaded after reset
    input wire logic nv_lockdown_in,
    input wire logic nv_mode_in,
    // Range protection write
    input wire logic bp_wr_stb,
    input wire logic [3:0] bp_wr_data,
    // Array engine
    input wire logic [31:0] chk_addr,
    input wire logic prog_start,
    input wire logic erase_start,
    input wire logic otp_access,
    input wire logic prog_fail_evt,
    input wire logic erase_fail_evt,
    // Status out
    output logic [3:0] block_protect_bits,
    output logic chk_protected,
    output logic [7:0] security_reg,
    output logic otp_lockdown_bit,
    output logic protect_mode_select,
    output logic write_enable_latch
);

    localparam int BW = $clog2(NUM_BLOCKS);
    localparam int DEPTH = NUM_BLOCKS + 2 * `FP_SECS_PER_BLK;
    localparam int UW = $clog2(DEPTH);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Lock unit of an address: end blocks split into sectors
    function automatic logic [UW-1:0] fp_unit(input logic [31:0] a);
        logic [BW-1:0] blk;
        logic [`FP_SEC_W-1:0] sec;
        blk = a[`FP_BLK_LSB +: BW];
        sec = a[`FP_SEC_LSB +: `FP_SEC_W];
        if (blk == '0) begin
            return UW'(NUM_BLOCKS) + UW'(sec);
        end else if (blk == BW'(NUM_BLOCKS - 1)) begin
            return UW'(NUM_BLOCKS + `FP_SECS_PER_BLK) + UW'(sec);
        end
        return UW'(blk);
    endfunction : fp_unit

    // Range protection covers the top 2^(bp-1) blocks
    function automatic logic fp_bp_covers(input logic [3:0] bp, input logic [BW-1:0] blk);
        int span;
        span = (bp == `FP_BP_RESET) ? 0 : (1 << (int'(bp) - 1));
        return (int'(blk) >= (NUM_BLOCKS - span));
    endfunction : fp_bp_covers

    // Parameter table contents, header signature only
    function automatic logic [7:0] fp_param_byte(input logic [23:0] a);
        unique case (a)
            24'h000000: return `FP_SIG_B0;
            24'h000001: return `FP_SIG_B1;
            24'h000002: return `FP_SIG_B2;
            24'h000003: return `FP_SIG_B3;
            default: return `FP_TBL_FILL;
        endcase
    endfunction : fp_param_byte

    // Opcode to command kind
    function automatic fprot_cmd_t fp_decode(input logic [7:0] op);
        if (op == OP_SEC_WR) return fprot_sec_wr;
        if (op == OP_MODESEL) return fprot_modesel;
        if (op == OP_WR_EN) return fprot_wr_en;
        if (op == OP_WRDI) return fprot_wrdi;
        if (op == `FP_OP_LOCK1) return fprot_lock1;
        if (op == `FP_OP_UNLOCK1) return fprot_unlock1;
        if (op == `FP_OP_LOCKALL) return fprot_lockall;
        if (op == `FP_OP_UNLOCKALL) return fprot_unlockall;
        if (op == `FP_OP_CLRFAIL) return fprot_clrfail;
        if (op == OP_RDY_ON) return fprot_rdy_on;
        if (op == OP_RDY_OFF) return fprot_rdy_off;
        return fprot_none;
    endfunction : fp_decode

    // ****************************************************************
    // Link side, rising edge receive
    // ****************************************************************
    logic in_frame_reg;
    logic [7:0] rx_sh_reg;
    logic [2:0] bit_cnt_reg;
    logic [2:0] byte_cnt_reg;
    logic [7:0] opcode_reg;
    logic [31:0] addr_reg;
    logic frame_tog_reg;
    logic [7:0] tx_sh_reg;
    logic [23:0] tbl_ptr_reg;
    logic so_reg;
    logic so_oe_reg;
    logic mode_reg;
    logic lock_rd_bit;
    wire [7:0] rx_byte = {rx_sh_reg[6:0], si};

    // Frame marker, cleared by chip select itself
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            in_frame_reg <= 1'b0;
        end else begin
            in_frame_reg <= 1'b1;
        end
    end

    // Shift in MSB first, first edge restarts decode
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sh_reg <= 8'h00;
            bit_cnt_reg <= `FP_BIT_ZERO;
            byte_cnt_reg <= `FP_BYTE_ZERO;
            opcode_reg <= 8'h00;
            addr_reg <= 32'h00000000;
            frame_tog_reg <= 1'b0;
        end else if (!in_frame_reg) begin
            rx_sh_reg <= {7'h00, si}; // [RULE27]
            bit_cnt_reg <= `FP_BIT_FIRST;
            byte_cnt_reg <= `FP_BYTE_ZERO;
            frame_tog_reg <= ~frame_tog_reg;
        end else begin
            rx_sh_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == `FP_BIT_LAST) begin
                if (byte_cnt_reg != `FP_LEN_DATA) begin
                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                end
                if (byte_cnt_reg == `FP_BYTE_ZERO) begin
                    opcode_reg <= rx_byte;
                end else if (byte_cnt_reg < `FP_LEN_ADDR4) begin
                    addr_reg <= {addr_reg[23:0], rx_byte}; // [RULE12] [RULE22]
                end
            end
        end
    end

    // ****************************************************************
    // Link side, falling edge transmit
    // ****************************************************************
    wire tx_lock_rd = (opcode_reg == `FP_OP_RDBLK) && mode_reg; // [RULE10]
    wire tx_sfdp = (opcode_reg == `FP_OP_SFDP);
    wire tx_first = (byte_cnt_reg == `FP_LEN_ADDR4);
    wire tx_load = (bit_cnt_reg == `FP_BIT_ZERO) && (tx_first || (byte_cnt_reg == `FP_LEN_DATA))
        && (tx_lock_rd || tx_sfdp);
    wire [23:0] tx_tbl_addr = tx_first ? addr_reg[`FP_SFDP_LSB +: 24] : tbl_ptr_reg;
    wire [7:0] tx_lock_byte = lock_rd_bit ? `FP_BYTE_ONES : `FP_BYTE_ZEROS; // [RULE16]
    wire [7:0] tx_byte = tx_sfdp ? fp_param_byte(tx_tbl_addr) : tx_lock_byte; // [RULE15] [RULE22]

    // Drive SO, released the moment chip select rises
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            so_reg <= 1'b0; // [RULE23]
            so_oe_reg <= 1'b0;
            tx_sh_reg <= 8'h00;
            tbl_ptr_reg <= 24'h000000;
        end else if (tx_load) begin
            so_reg <= tx_byte[7];
            so_oe_reg <= 1'b1;
            tx_sh_reg <= {tx_byte[6:0], 1'b0};
            tbl_ptr_reg <= tx_tbl_addr + 24'h000001;
        end else begin
            so_reg <= tx_sh_reg[7];
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
    end

    assign so_out = so_reg;
    assign so_oe = so_oe_reg;

    // ****************************************************************
    // Crossing into the system clock
    // ****************************************************************
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_seen_reg;
    logic wp_s1_reg;
    logic wp_s2_reg;

    // Two-stage synchronisers for chip select, frame toggle, wp pin
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_seen_reg <= 1'b0;
            wp_s1_reg <= 1'b1;
            wp_s2_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            tog_s1_reg <= frame_tog_reg;
            tog_s2_reg <= tog_s1_reg;
            if (cs_s2_reg && !cs_s3_reg) begin
                tog_seen_reg <= tog_s2_reg;
            end
            wp_s1_reg <= wp_n;
            wp_s2_reg <= wp_s1_reg;
        end
    end

    // ****************************************************************
    // Command decode at frame end
    // ****************************************************************
    logic lockdown_reg;
    logic wel_reg;
    logic pfail_reg;
    logic efail_reg;
    logic rdy_en_reg;
    logic init_pend_reg;

    wire frame_end = cs_s2_reg && !cs_s3_reg && (tog_s2_reg != tog_seen_reg);
    fprot_cmd_t cmd_kind;
    assign cmd_kind = fp_decode(opcode_reg);
    wire cmd_addr = (cmd_kind == fprot_lock1) || (cmd_kind == fprot_unlock1);
    wire cmd_global = (cmd_kind == fprot_lockall) || (cmd_kind == fprot_unlockall);
    wire len_ok = (bit_cnt_reg == `FP_BIT_ZERO)
        && (byte_cnt_reg == (cmd_addr ? `FP_LEN_ADDR4 : `FP_LEN_OPONLY)); // [RULE2] [RULE12]
    wire exec = frame_end && len_ok && (cmd_kind != fprot_none); // [RULE26]
    wire lock_ok = exec && mode_reg && wel_reg && (cmd_addr || cmd_global); // [RULE10] [RULE14]
    wire mem_wr_en = lock_ok && cmd_addr;
    wire mem_all_en = lock_ok && cmd_global; // [RULE17]
    wire mem_wr_data = (cmd_kind == fprot_lock1); // [RULE11]
    wire mem_all_data = (cmd_kind == fprot_lockall);
    wire [UW-1:0] mem_wr_addr = fp_unit(addr_reg); // [RULE13]
    wire lock_chk_bit;

    // Per-block volatile lock bits
    fprot_lockmem #(
        .DEPTH(DEPTH),
        .AW(UW)
    ) u_lockmem (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data),
        .all_en(mem_all_en),
        .all_data(mem_all_data),
        .rd_a_addr(mem_wr_addr),
        .rd_a_data(lock_rd_bit),
        .rd_b_addr(fp_unit(chk_addr)),
        .rd_b_data(lock_chk_bit)
    );

    // ****************************************************************
    // Protection state and flags
    // ****************************************************************
    logic [3:0] bp_reg;
    logic chk_prot_reg;
    logic [7:0] sec_reg;
    logic rdy_out_reg;
    logic rdy_oe_reg;

    wire bp_frozen = status_write_disable_bit && !wp_s2_reg;
    wire [3:0] bp_next = (bp_wr_stb && !bp_frozen) ? bp_wr_data : bp_reg; // [RULE7]
    wire lockdown_next = lockdown_reg || (exec && (cmd_kind == fprot_sec_wr)); // [RULE1]
    wire mode_next = mode_reg || (exec && (cmd_kind == fprot_modesel)); // [RULE4] [RULE9]
    wire wel_next = (exec && (cmd_kind == fprot_wr_en)) ? 1'b1
        : ((exec && (cmd_kind == fprot_wrdi)) || lock_ok) ? 1'b0 : wel_reg;
    wire clr_fail = exec && (cmd_kind == fprot_clrfail); // [RULE18] [RULE24]
    wire otp_block = otp_access && lockdown_reg;
    wire pfail_set = prog_fail_evt || (prog_start && (chk_prot_reg || otp_block)); // [RULE25]
    wire efail_set = erase_fail_evt || (erase_start && (chk_prot_reg || otp_block));
    wire pfail_next = pfail_set || (pfail_reg && !clr_fail);
    wire efail_next = efail_set || (efail_reg && !clr_fail);
    wire rdy_next = !continuous_program_mode ? 1'b0
        : (exec && (cmd_kind == fprot_rdy_on)) ? 1'b1 // [RULE20]
        : (exec && (cmd_kind == fprot_rdy_off)) ? 1'b0 : rdy_en_reg; // [RULE21]
    wire blk_prot = !wp_s2_reg || lock_chk_bit; // [RULE5] [RULE6] [RULE8]
    wire range_prot = fp_bp_covers(bp_reg, chk_addr[`FP_BLK_LSB +: BW]);
    wire chk_prot_next = mode_reg ? blk_prot : range_prot; // [RULE3]

    // Security register image
    logic [7:0] sec_next;
    always_comb begin
        sec_next = `FP_SEC_RESET;
        sec_next[`FP_SEC_MODE] = mode_reg;
        sec_next[`FP_SEC_EFAIL] = efail_reg;
        sec_next[`FP_SEC_PFAIL] = pfail_reg;
        sec_next[`FP_SEC_CP] = continuous_program_mode;
        sec_next[`FP_SEC_LOCKDN] = lockdown_reg;
        sec_next[`FP_SEC_FACT] = factory_lock;
    end

    // Sticky bits load their stored image after reset
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            init_pend_reg <= 1'b1;
            lockdown_reg <= 1'b0;
            mode_reg <= 1'b0;
        end else if (init_pend_reg) begin
            init_pend_reg <= 1'b0;
            lockdown_reg <= nv_lockdown_in;
            mode_reg <= nv_mode_in;
        end else begin
            lockdown_reg <= lockdown_next;
            mode_reg <= mode_next;
        end
    end

    // Volatile state and registered outputs
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wel_reg <= 1'b0;
            pfail_reg <= 1'b0;
            efail_reg <= 1'b0;
            rdy_en_reg <= 1'b0;
            bp_reg <= `FP_BP_RESET;
            chk_prot_reg <= 1'b0;
            sec_reg <= `FP_SEC_RESET;
            rdy_out_reg <= 1'b0;
            rdy_oe_reg <= 1'b0;
        end else begin
            wel_reg <= wel_next;
            pfail_reg <= pfail_next;
            efail_reg <= efail_next;
            rdy_en_reg <= rdy_next;
            bp_reg <= bp_next;
            chk_prot_reg <= chk_prot_next;
            sec_reg <= sec_next;
            rdy_out_reg <= ready_busy_n;
            rdy_oe_reg <= rdy_en_reg && cs_s2_reg; // [RULE20]
        end
    end

    assign rdy_so_out = rdy_out_reg;
    assign rdy_so_oe = rdy_oe_reg;
    assign block_protect_bits = bp_reg;
    assign chk_protected = chk_prot_reg;
    assign security_reg = sec_reg;
    assign otp_lockdown_bit = lockdown_reg;
    assign protect_mode_select = mode_reg;
    assign write_enable_latch = wel_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking fp_cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_mode_sticky: assert property (!init_pend_reg && mode_reg |=> mode_reg) // [RULE4]
        else $error("mode select bit returned to zero");
    a_lockdown_sticky: assert property (!init_pend_reg && lockdown_reg |=> lockdown_reg) // [RULE1]
        else $error("lockdown bit cleared");
    a_wp_protect: assert property (mode_reg && !wp_s2_reg |=> chk_protected) // [RULE8]
        else $error("wp low did not protect in per-block mode");
    a_bp_frozen: assert property (status_write_disable_bit && !wp_s2_reg |=> $stable(block_protect_bits)) // [RULE7]
        else $error("range bits changed while frozen");
    a_flag_clear: assert property (clr_fail && !prog_fail_evt && !prog_start && !erase_fail_evt && !erase_start
        |=> !pfail_reg && !efail_reg ##1 !security_reg[`FP_SEC_PFAIL]) // [RULE18]
        else $error("flag clear did not reset fail flags");
    a_lock_gated: assert property ((mem_wr_en || mem_all_en) |-> mode_reg && wel_reg && len_ok) // [RULE10]
        else $error("lock write without mode, enable or framing");
    a_wel_used: assert property (lock_ok |=> !write_enable_latch) // [RULE14]
        else $error("write enable not consumed by lock command");
    a_reject_keep: assert property (frame_end && !len_ok |=> $stable(pfail_reg) || $past(pfail_set)) // [RULE26]
        else $error("rejected frame changed fail flag");
    a_pfail_set: assert property (prog_fail_evt |=> pfail_reg ##1 security_reg[`FP_SEC_PFAIL]) // [RULE25]
        else $error("program fail not flagged");
    a_rdy_stop: assert property (!rdy_en_reg |=> !rdy_so_oe) // [RULE21]
        else $error("ready driven on SO while disabled");
    a_rdy_start: assert property (exec && cmd_kind == fprot_rdy_on && continuous_program_mode
        ##1 continuous_program_mode && cs_s2_reg |=> rdy_so_oe) // [RULE20]
        else $error("ready not driven after enable");
    a_mode_set: assert property (!init_pend_reg && exec && cmd_kind == fprot_modesel |=> ##1 security_reg[`FP_SEC_MODE]) // [RULE9]
        else $error("mode select command not reflected");

    c_single_unlock: cover property (mem_wr_en && !mem_wr_data);
    c_global_lock: cover property (mem_all_en && mem_all_data);
    c_reject_frame: cover property (frame_end && !len_ok);
    c_ready_out: cover property (rdy_so_oe);

endmodule : fprot_core

`default_nettype wire

// file: fprot_defs.svh
`ifndef FPROT_DEFS_SVH
`define FPROT_DEFS_SVH

// ****************************************************************
// Fixed opcodes of the protection commands
// ****************************************************************
`define FP_OP_LOCK1 8'h36
`define FP_OP_UNLOCK1 8'h39
`define FP_OP_RDBLK 8'h3C
`define FP_OP_LOCKALL 8'h7E
`define FP_OP_UNLOCKALL 8'h98
`define FP_OP_CLRFAIL 8'h30
`define FP_OP_SFDP 8'h5A

// ****************************************************************
// Frame lengths counted in whole bytes, and bit counter values
// ****************************************************************
`define FP_LEN_OPONLY 3'h1
`define FP_LEN_ADDR4 3'h5
`define FP_LEN_DATA 3'h6
`define FP_BIT_LAST 3'h7
`define FP_BIT_FIRST 3'h1
`define FP_BIT_ZERO 3'h0
`define FP_BYTE_ZERO 3'h0

// ****************************************************************
// Security register bit positions and reset values
// ****************************************************************
`define FP_SEC_MODE 7
`define FP_SEC_EFAIL 6
`define FP_SEC_PFAIL 5
`define FP_SEC_CP 4
`define FP_SEC_LOCKDN 1
`define FP_SEC_FACT 0
`define FP_SEC_RESET 8'h00
`define FP_BP_RESET 4'h0

// ****************************************************************
// Address decode of lock units
// ****************************************************************
`define FP_BLK_LSB 16
`define FP_SEC_LSB 12
`define FP_SEC_W 4
`define FP_SECS_PER_BLK 16
`define FP_SFDP_LSB 8

// ****************************************************************
// Parameter table header and fill values
// ****************************************************************
`define FP_SIG_B0 8'h53
`define FP_SIG_B1 8'h46
`define FP_SIG_B2 8'h44
`define FP_SIG_B3 8'h50
`define FP_TBL_FILL 8'hFF
`define FP_BYTE_ONES 8'hFF
`define FP_BYTE_ZEROS 8'h00

`endif

// file: fprot_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host side of the serial link
// ****************************************************************
module fprot_host (
    // Link pins
    output var logic sclk,
    output var logic cs_n,
    output var logic si,
    input wire logic so
);
    // Idle link: clock still, chip deselected
    // Late start, so the first select edge is seen by the link flops
    initial begin
        #1;
        sclk = 1'h0;
        cs_n = 1'h1;
        si = 1'h0;
    end

    // Frame of nb bits MSB first, then one byte in if rd, 80 ns link clock
    task automatic xfer(input logic [39:0] d, input int nb, input bit rd, output logic [7:0] q);
        q = 8'h00;
        cs_n = 1'h0;
        for (int i = 0; i < nb + 8 * rd; i++) begin
            si = (i < nb) ? d[39 - i] : ~si;
            #40 sclk = 1'h1;
            if (i >= nb) q = {q[6:0], so};
            #40 sclk = 1'h0;
        end
        #40 cs_n = 1'h1;
        si = ~si;
        #200;
    endtask : xfer
endmodule : fprot_host

`default_nettype wire

// file: fprot_lockmem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Volatile lock bit store, two registered read ports
// ****************************************************************
module fprot_lockmem #(
    parameter int DEPTH = 544,
    parameter int AW = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Single unit write
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic wr_data,
    // Whole array write
    input wire logic all_en,
    input wire logic all_data,
    // Read ports
    input wire logic [AW-1:0] rd_a_addr,
    output logic rd_a_data,
    input wire logic [AW-1:0] rd_b_addr,
    output logic rd_b_data
);

    logic [DEPTH-1:0] bits_reg;
    logic rd_a_reg;
    logic rd_b_reg;

    // Lock bits come up all set
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bits_reg <= '1;
        end else if (all_en) begin
            bits_reg <= {DEPTH{all_data}};
        end else if (wr_en) begin
            bits_reg[wr_addr] <= wr_data;
        end
    end

    // Registered reads
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rd_a_reg <= 1'b1;
            rd_b_reg <= 1'b1;
        end else begin
            rd_a_reg <= bits_reg[rd_a_addr];
            rd_b_reg <= bits_reg[rd_b_addr];
        end
    end

    assign rd_a_data = rd_a_reg;
    assign rd_b_data = rd_b_reg;

endmodule : fprot_lockmem

`default_nettype wire

// file: fprot_pkg.sv
`default_nettype none

// ****************************************************************
// Shared types of the protection command block
// ****************************************************************
package fprot_pkg;

    // Decoded command kinds
    typedef enum logic [3:0] {
        fprot_none,
        fprot_sec_wr,
        fprot_modesel,
        fprot_wr_en,
        fprot_wrdi,
        fprot_lock1,
        fprot_unlock1,
        fprot_lockall,
        fprot_unlockall,
        fprot_clrfail,
        fprot_rdy_on,
        fprot_rdy_off
    } fprot_cmd_t;

endpackage : fprot_pkg

`default_nettype wire

// file: tb_serial_flash_protection_commands.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Bench of the protection command block
// ****************************************************************
module tb_serial_flash_protection_commands;
    logic mclk, rst_b, wp_n, status_write_disable_bit, continuous_program_mode, ready_busy_n, factory_lock;
    logic nv_lockdown_in, nv_mode_in, bp_wr_stb, prog_start, erase_start, otp_access, prog_fail_evt, erase_fail_evt;
    logic so_out, so_oe, rdy_so_out, rdy_so_oe, chk_protected, otp_lockdown_bit, protect_mode_select;
    logic write_enable_latch;
    logic [3:0] bp_wr_data, block_protect_bits;
    logic [31:0] chk_addr;
    logic [7:0] security_reg, q;
    wire logic sclk, cs_n, si, so;
    int miscompares, checks_done;

    // Shared SO line: read data in frames, ready status between them
    assign so = so_oe ? so_out : (rdy_so_oe ? rdy_so_out : ~si);

    fprot_core dut_u (.mclk, .rst_b, .sclk, .cs_n, .si, .so_out, .so_oe, .rdy_so_out, .rdy_so_oe, .wp_n,
        .status_write_disable_bit, .continuous_program_mode, .ready_busy_n, .factory_lock, .nv_lockdown_in,
        .nv_mode_in, .bp_wr_stb, .bp_wr_data, .chk_addr, .prog_start, .erase_start, .otp_access, .prog_fail_evt,
        .erase_fail_evt, .block_protect_bits, .chk_protected, .security_reg, .otp_lockdown_bit,
        .protect_mode_select, .write_enable_latch);
    fprot_host h (.sclk, .cs_n, .si, .so);

    // Clock and watchdog
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        #500000 miscompares++;
        final_report();
    end

    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic op(input logic [7:0] o);
        h.xfer({o, 32'h0}, 8, 1'b0, q);
    endtask : op
    task automatic at(input logic [31:0] a);
        chk_addr = a;
        cyc(3);
    endtask : at
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bpw(input logic [3:0] v);
        bp_wr_data = v;
        bp_wr_stb = 1'h1;
        cyc(1);
        bp_wr_stb = 1'h0;
        cyc(2);
    endtask : bpw
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // Test sequence
    initial begin
        #1;
        {rst_b, status_write_disable_bit, continuous_program_mode, factory_lock, nv_lockdown_in} = '0;
        {nv_mode_in, bp_wr_stb, prog_start, erase_start, otp_access, prog_fail_evt, erase_fail_evt} = '0;
        {wp_n, ready_busy_n, bp_wr_data, chk_addr} = {2'h3, 36'h0};
        cyc(6);
        rst_b = 1'h1;
        cyc(4);
        chk(security_reg, 8'h00);
        status_write_disable_bit = 1'h1;
        wp_n = 1'h0;
        cyc(3);
        bpw(4'h3);
        chk(block_protect_bits, 4'h0);
        status_write_disable_bit = 1'h0;
        bpw(4'h3);
        chk(block_protect_bits, 4'h3);
        wp_n = 1'h1;
        at(32'h01FF_0000);
        chk(chk_protected, 1'h1);
        at(32'h0);
        chk(chk_protected, 1'h0);
        op(8'h06);
        op(8'h98);
        $display("test 1 done");
        op(8'h68);
        chk(security_reg[7], 1'h1);
        chk(protect_mode_select, 1'h1);
        cyc(3);
        chk(chk_protected, 1'h1);
        h.xfer({8'h3C, 32'h0005_0000}, 40, 1'b1, q);
        chk(q, 8'hFF);
        op(8'h04);
        op(8'h98);
        cyc(3);
        chk(chk_protected, 1'h1);
        op(8'h06);
        op(8'h98);
        chk(chk_protected, 1'h0);
        wp_n = 1'h0;
        cyc(5);
        chk(chk_protected, 1'h1);
        wp_n = 1'h1;
        $display("test 2 done");
        op(8'h06);
        chk(write_enable_latch, 1'h1);
        h.xfer({8'h36, 32'h0005_0000}, 40, 1'b0, q);
        at(32'h0005_0000);
        chk(chk_protected, 1'h1);
        at(32'h0006_0000);
        chk(chk_protected, 1'h0);
        op(8'h06);
        h.xfer({8'h39, 32'h0005_0000}, 37, 1'b0, q);
        at(32'h0005_0000);
        chk(chk_protected, 1'h1);
        h.xfer({8'h3C, 32'h0006_0000}, 40, 1'b1, q);
        chk(q, 8'h00);
        $display("test 3 done");
        prog_start = 1'h1;
        cyc(1);
        prog_start = 1'h0;
        cyc(3);
        chk(security_reg[5], 1'h1);
        op(8'h30);
        chk(security_reg[5], 1'h0);
        op(8'h2F);
        chk(otp_lockdown_bit, 1'h1);
        at(32'h0006_0000);
        otp_access = 1'h1;
        erase_start = 1'h1;
        cyc(1);
        erase_start = 1'h0;
        otp_access = 1'h0;
        cyc(3);
        chk(security_reg[6], 1'h1);
        $display("test 4 done");
        h.xfer({8'h5A, 32'h0}, 40, 1'b1, q);
        chk(q, 8'h53);
        chk(so_oe, 1'h0);
        continuous_program_mode = 1'h1;
        ready_busy_n = 1'h0;
        op(8'h70);
        chk(rdy_so_oe, 1'h1);
        chk(so, 1'h0);
        op(8'h80);
        chk(rdy_so_oe, 1'h0);
        $display("test 5 done");
        final_report();
    end
endmodule : tb_serial_flash_protection_commands

`default_nettype wire
